//--- logic/csda_core.sv
// Sequencer for compare-and-skip and decimal adjust, with data memory and registers
`timescale 1ns/1ps
module csda_core (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_reset_n,
    // Instruction issue
    input  wire logic        i_instr_valid,
    input  wire logic [15:0] i_instr,
    input  wire logic        i_next_two_word,
    output logic             o_instr_ready,
    // Execution status
    output logic             o_busy,
    output logic             o_skip,
    output logic             o_done,
    output logic       [1:0] o_cycles,
    output logic       [1:0] o_phase,
    // Register port
    input  wire logic  [7:0] i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    input  wire logic        i_reg_write,
    input  wire logic        i_reg_read,
    output logic      [31:0] o_reg_rdata
);
    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic reset_meta_n;
    logic reset_n;

    // Release synchronised; assertion stays asynchronous
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            reset_meta_n <= 1'b0;
            reset_n      <= 1'b0;
        end else begin
            reset_meta_n <= 1'b1;
            reset_n      <= reset_meta_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State
    csda_pkg::csda_state_type state;
    csda_pkg::csda_state_type next_state;
    csda_pkg::csda_phase_type phase;
    logic [15:0] instr;
    logic        two_word;
    logic [7:0]  operand;
    logic        skip;
    logic        skip_left;
    logic [11:0] resolved;
    logic [7:0]  working_register_alias;
    logic [3:0]  bank_select_register;
    logic [11:0] index_base;
    logic        ext_en;
    logic        carry_flag;
    logic        digit_carry_flag;
    logic [11:0] mem_addr;
    logic [7:0]  general_purpose_file [0:4095];

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    wire [6:0] opcode;
    wire       is_equal;
    wire       is_greater;
    wire       is_less;
    wire       is_compare;
    wire       is_adjust;
    wire       take_skip;
    wire       accept;
    wire       last_phase;
    wire       finish;

    assign opcode     = instr[15:9];
    assign is_equal   = opcode == csda_pkg::CSDA_OP_SKIP_EQUAL;
    assign is_greater = opcode == csda_pkg::CSDA_OP_SKIP_GREATER;
    assign is_less    = opcode == csda_pkg::CSDA_OP_SKIP_LESS;
    assign is_compare = is_equal || is_greater || is_less;
    assign is_adjust  = instr == csda_pkg::CSDA_OP_DECIMAL_ADJ;
    assign accept     = i_instr_valid && o_instr_ready;
    assign last_phase = phase == csda_pkg::CSDA_Q4;

    // Unsigned compare only; no result or flag is written
    assign take_skip = (is_equal   && (operand == working_register_alias)) ||
                       (is_greater && (operand >  working_register_alias)) ||
                       (is_less    && (operand <  working_register_alias));

    ////////////////////////////////////////////////////////////////////////////
    // Address resolution
    csda_addr_if addr_bus ();

    // Full 8-bit field and one access bit straight from the word
    assign addr_bus.file_addr  = instr[7:0];
    assign addr_bus.access     = instr[csda_pkg::CSDA_ACCESS_BIT];
    assign addr_bus.ext_en     = ext_en;
    assign addr_bus.bank       = bank_select_register;
    assign addr_bus.index_base = index_base;

    csda_addr_map u_addr_map (
        .port (addr_bus.resolver)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Decimal adjust datapath
    wire [7:0] adjusted;
    wire       adjusted_carry;

    csda_bcd_adjust u_bcd_adjust (
        .i_value       (working_register_alias),
        .i_digit_carry (digit_carry_flag),
        .i_carry       (carry_flag),
        .o_value       (adjusted),
        .o_carry       (adjusted_carry)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    wire exec_end;
    wire skip_end;
    wire adjust_write;

    assign exec_end     = (state == csda_pkg::CSDA_EXEC) && last_phase;
    assign skip_end     = (state == csda_pkg::CSDA_SKIP) && last_phase && !skip_left;
    assign finish       = (exec_end && !skip) || skip_end;
    // Adjusted value lands in the fourth phase of its single cycle
    assign adjust_write = (state == csda_pkg::CSDA_EXEC) && last_phase && is_adjust;

    always_comb begin
        next_state = state;
        unique case (state)
            csda_pkg::CSDA_IDLE: begin
                if (accept) begin
                    next_state = csda_pkg::CSDA_EXEC;
                end
            end
            csda_pkg::CSDA_EXEC: begin
                if (last_phase) begin
                    next_state = skip ? csda_pkg::CSDA_SKIP : csda_pkg::CSDA_IDLE;
                end
            end
            csda_pkg::CSDA_SKIP: begin
                if (last_phase && !skip_left) begin
                    next_state = csda_pkg::CSDA_IDLE;
                end
            end
            default: begin
                next_state = csda_pkg::CSDA_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    // Phases run Q1..Q4 in every busy cycle; idle holds Q1
    always_ff @(posedge i_core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= csda_pkg::CSDA_IDLE;
            phase <= csda_pkg::CSDA_Q1;
        end else begin
            state <= next_state;
            phase <= (state == csda_pkg::CSDA_IDLE) ? csda_pkg::CSDA_Q1
                                                    : csda_pkg::csda_phase_type'(phase + 2'b01);
        end
    end

    // Q1 decode, Q2 file read, Q3 compare, Q4 idle
    always_ff @(posedge i_core_clk or negedge reset_n) begin
        if (!reset_n) begin
            instr    <= 16'h0000;
            two_word <= 1'b0;
            resolved <= 12'h000;
            operand  <= 8'h00;
            skip     <= 1'b0;
        end else begin
            if (accept) begin
                instr    <= i_instr;
                two_word <= i_next_two_word;
                skip     <= 1'b0;
            end
            if (state == csda_pkg::CSDA_EXEC) begin
                unique case (phase)
                    csda_pkg::CSDA_Q1: resolved <= addr_bus.resolved;
                    csda_pkg::CSDA_Q2: operand  <= general_purpose_file[resolved];
                    csda_pkg::CSDA_Q3: skip     <= is_compare && take_skip;
                    csda_pkg::CSDA_Q4: operand  <= operand;
                endcase
            end
        end
    end

    // A two-word follower costs one more idle cycle
    always_ff @(posedge i_core_clk or negedge reset_n) begin
        if (!reset_n) begin
            skip_left <= 1'b0;
        end else if (exec_end) begin
            skip_left <= skip && two_word;
        end else if ((state == csda_pkg::CSDA_SKIP) && last_phase) begin
            skip_left <= 1'b0;
        end
    end

    // Cycle count and completion pulse
    always_ff @(posedge i_core_clk or negedge reset_n) begin
        if (!reset_n) begin
            o_cycles <= 2'b00;
            o_done   <= 1'b0;
        end else begin
            o_done <= finish;
            if (finish) begin
                o_cycles <= 2'b01 + {1'b0, skip} + {1'b0, skip && two_word};
            end
        end
    end

    assign o_instr_ready = state == csda_pkg::CSDA_IDLE;
    assign o_busy        = state != csda_pkg::CSDA_IDLE;
    assign o_skip        = state == csda_pkg::CSDA_SKIP;
    assign o_phase       = phase;

    ////////////////////////////////////////////////////////////////////////////
    // Register port decode
    wire wr_ctrl;
    wire wr_work;
    wire wr_bank;
    wire wr_status;
    wire wr_index;
    wire wr_mem_addr;
    wire wr_mem_data;
    wire [31:0] read_mux;

    assign wr_ctrl     = i_reg_write && (i_reg_addr == csda_pkg::CSDA_OFS_CTRL);
    assign wr_work     = i_reg_write && (i_reg_addr == csda_pkg::CSDA_OFS_WORK);
    assign wr_bank     = i_reg_write && (i_reg_addr == csda_pkg::CSDA_OFS_BANK);
    assign wr_status   = i_reg_write && (i_reg_addr == csda_pkg::CSDA_OFS_STATUS);
    assign wr_index    = i_reg_write && (i_reg_addr == csda_pkg::CSDA_OFS_INDEX);
    assign wr_mem_addr = i_reg_write && (i_reg_addr == csda_pkg::CSDA_OFS_MEM_ADDR);
    assign wr_mem_data = i_reg_write && (i_reg_addr == csda_pkg::CSDA_OFS_MEM_DATA);

    // Unmapped offsets read zero
    assign read_mux =
        (i_reg_addr == csda_pkg::CSDA_OFS_CTRL)     ? {31'h0, ext_en} :
        (i_reg_addr == csda_pkg::CSDA_OFS_WORK)     ? {24'h0, working_register_alias} :
        (i_reg_addr == csda_pkg::CSDA_OFS_BANK)     ? {28'h0, bank_select_register} :
        (i_reg_addr == csda_pkg::CSDA_OFS_STATUS)   ? {30'h0, digit_carry_flag, carry_flag} :
        (i_reg_addr == csda_pkg::CSDA_OFS_INDEX)    ? {20'h0, index_base} :
        (i_reg_addr == csda_pkg::CSDA_OFS_MEM_ADDR) ? {20'h0, mem_addr} :
        (i_reg_addr == csda_pkg::CSDA_OFS_MEM_DATA) ? {24'h0, general_purpose_file[mem_addr]} :
        (i_reg_addr == csda_pkg::CSDA_OFS_RESULT)   ? {4'h0, resolved, 13'h0, skip, o_cycles} :
                                                      32'h0000_0000;

    // Read data valid only the cycle after the strobe
    always_ff @(posedge i_core_clk or negedge reset_n) begin
        if (!reset_n) begin
            o_reg_rdata <= 32'h0000_0000;
        end else begin
            o_reg_rdata <= i_reg_read ? read_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-visible registers
    // Decimal adjust write wins over a same-cycle software write
    always_ff @(posedge i_core_clk or negedge reset_n) begin
        if (!reset_n) begin
            working_register_alias <= csda_pkg::CSDA_WORK_RST;
            carry_flag             <= 1'b0;
            digit_carry_flag       <= 1'b0;
        end else if (adjust_write) begin
            working_register_alias <= adjusted;
            carry_flag             <= adjusted_carry;
        end else begin
            if (wr_work) begin
                working_register_alias <= i_reg_wdata[7:0];
            end
            if (wr_status) begin
                carry_flag       <= i_reg_wdata[csda_pkg::CSDA_STAT_CARRY_BIT];
                digit_carry_flag <= i_reg_wdata[csda_pkg::CSDA_STAT_DIGIT_BIT];
            end
        end
    end

    // Control, bank, index and memory pointer
    always_ff @(posedge i_core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_en               <= csda_pkg::CSDA_EXT_RST;
            bank_select_register <= csda_pkg::CSDA_BANK_RST;
            index_base           <= csda_pkg::CSDA_INDEX_RST;
            mem_addr             <= 12'h000;
        end else begin
            if (wr_ctrl) begin
                ext_en <= i_reg_wdata[csda_pkg::CSDA_CTRL_EXT_BIT];
            end
            if (wr_bank) begin
                bank_select_register <= i_reg_wdata[3:0];
            end
            if (wr_index) begin
                index_base <= i_reg_wdata[11:0];
            end
            if (wr_mem_addr) begin
                mem_addr <= i_reg_wdata[11:0];
            end
        end
    end

    // Data memory has no reset; software loads it before use
    always_ff @(posedge i_core_clk) begin
        if (wr_mem_data) begin
            general_purpose_file[mem_addr] <= i_reg_wdata[7:0];
        end
    end
endmodule

//--- logic/csda_pkg.sv
// Constants and types shared by the compare-skip and decimal-adjust logic
//
// Function
// - Decode skip-if-greater opcode 0110 010a
// - Decode skip-if-less opcode 0110 000a
// - Unsigned compare, nothing stored, flags untouched
// - Greater skips only when file above working
// - Less skips only when file below working
// - Taken skip replaces fetched word with idle
// - One, two or three cycles per compare
// - Access bit zero selects access bank
// - Access bit one uses bank select
// - Extended set, low addresses use indexed offset
// - Low nibble plus six above nine/digit carry
// - Decimal adjust one cycle, carry only
// - Equal compare skips when values match
package csda_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // Register map (byte offsets on the plain register port)
    localparam logic [7:0] CSDA_OFS_CTRL     = 8'h00;
    localparam logic [7:0] CSDA_OFS_WORK     = 8'h04;
    localparam logic [7:0] CSDA_OFS_BANK     = 8'h08;
    localparam logic [7:0] CSDA_OFS_STATUS   = 8'h0C;
    localparam logic [7:0] CSDA_OFS_INDEX    = 8'h10;
    localparam logic [7:0] CSDA_OFS_MEM_ADDR = 8'h14;
    localparam logic [7:0] CSDA_OFS_MEM_DATA = 8'h18;
    localparam logic [7:0] CSDA_OFS_RESULT   = 8'h1C;
    // Field positions
    localparam int CSDA_CTRL_EXT_BIT    = 0;
    localparam int CSDA_STAT_CARRY_BIT  = 0;
    localparam int CSDA_STAT_DIGIT_BIT  = 1;
    localparam int CSDA_RES_SKIP_BIT    = 2;
    localparam int CSDA_RES_ADDR_LSB    = 16;
    // Reset values
    localparam logic [7:0]  CSDA_WORK_RST   = 8'h00;
    localparam logic [3:0]  CSDA_BANK_RST   = 4'h0;
    localparam logic [11:0] CSDA_INDEX_RST  = 12'h000;
    localparam logic        CSDA_EXT_RST    = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // Instruction encodings
    localparam logic [6:0]  CSDA_OP_SKIP_EQUAL   = 7'h31;  // 0110 001a
    localparam logic [6:0]  CSDA_OP_SKIP_GREATER = 7'h32;  // 0110 010a
    localparam logic [6:0]  CSDA_OP_SKIP_LESS    = 7'h30;  // 0110 000a
    localparam logic [15:0] CSDA_OP_DECIMAL_ADJ  = 16'h0007;
    localparam int          CSDA_ACCESS_BIT      = 8;
    // Address resolution
    localparam logic [7:0] CSDA_INDEXED_LIMIT = 8'h5F;  // 95
    localparam logic [7:0] CSDA_ACCESS_SPLIT  = 8'h80;
    localparam logic [3:0] CSDA_ACCESS_HIGH   = 4'hF;
    localparam logic [3:0] CSDA_ACCESS_LOW    = 4'h0;
    // Decimal adjust
    localparam logic [3:0] CSDA_DIGIT_MAX = 4'h9;
    localparam logic [4:0] CSDA_DIGIT_FIX = 5'h06;
    ////////////////////////////////////////////////////////////////////////////
    // Sequencing
    typedef enum logic [1:0] {
        CSDA_Q1 = 2'b00,
        CSDA_Q2 = 2'b01,
        CSDA_Q3 = 2'b10,
        CSDA_Q4 = 2'b11
    } csda_phase_type;
    typedef enum logic [1:0] {
        CSDA_IDLE = 2'b00,
        CSDA_EXEC = 2'b01,
        CSDA_SKIP = 2'b10
    } csda_state_type;
endpackage

//--- logic/csda_addr_if.sv
// Interface between the sequencer and the file address resolver
`timescale 1ns/1ps
interface csda_addr_if;
    logic [7:0]  file_addr;
    logic        access;
    logic        ext_en;
    logic [3:0]  bank;
    logic [11:0] index_base;
    logic [11:0] resolved;
    logic        indexed;
    modport requester (output file_addr, access, ext_en, bank, index_base,
                       input resolved, indexed);
    modport resolver  (input file_addr, access, ext_en, bank, index_base,
                       output resolved, indexed);
endinterface

//--- logic/csda_addr_map.sv
// Resolves an instruction's 8-bit file address to a 12-bit data address
`timescale 1ns/1ps
module csda_addr_map (
    // Address request and answer
    csda_addr_if.resolver  port
);
    wire use_indexed;
    wire low_half;

    // Indexed mode only with extended set, access bit clear, low addresses
    assign use_indexed = port.ext_en && !port.access &&
                         (port.file_addr <= csda_pkg::CSDA_INDEXED_LIMIT);
    assign low_half    = port.file_addr < csda_pkg::CSDA_ACCESS_SPLIT;
    assign port.indexed = use_indexed;
    // Bank select for access bit one, split access bank otherwise
    assign port.resolved =
        use_indexed ? 12'(port.index_base + {4'h0, port.file_addr}) :
        port.access ? {port.bank, port.file_addr} :
        low_half    ? {csda_pkg::CSDA_ACCESS_LOW, port.file_addr} :
                      {csda_pkg::CSDA_ACCESS_HIGH, port.file_addr};
endmodule

//--- logic/csda_bcd_adjust.sv
// Packed decimal correction of the working register
`timescale 1ns/1ps
module csda_bcd_adjust (
    // Operand and flags
    input  wire logic [7:0] i_value,
    input  wire logic       i_digit_carry,
    input  wire logic       i_carry,
    // Result
    output logic      [7:0] o_value,
    output logic            o_carry
);
    wire       fix_low;
    wire [4:0] low_sum;
    wire [4:0] high_in;
    wire       fix_high;
    wire [4:0] high_sum;

    // Low digit: add six above nine or after a digit carry
    assign fix_low  = (i_value[3:0] > csda_pkg::CSDA_DIGIT_MAX) || i_digit_carry;
    assign low_sum  = {1'b0, i_value[3:0]} + (fix_low ? csda_pkg::CSDA_DIGIT_FIX : 5'h00);
    // High digit takes the low carry, then the same correction
    assign high_in  = {1'b0, i_value[7:4]} + {4'h0, low_sum[4]};
    assign fix_high = (high_in > {1'b0, csda_pkg::CSDA_DIGIT_MAX}) || i_carry;
    assign high_sum = high_in + (fix_high ? csda_pkg::CSDA_DIGIT_FIX : 5'h00);
    assign o_value  = {high_sum[3:0], low_sum[3:0]};
    // A carry already set stays set, so chained decimal sums keep it
    assign o_carry  = high_sum[4] || i_carry;
endmodule

//--- testbench/csda_core_asserts.sv
// Concurrent checks on the ports of the compare-skip and decimal-adjust sequencer
`timescale 1ns/1ps
module csda_core_asserts (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_reset_n,
    // Instruction issue and status
    input  wire logic        i_instr_valid,
    input  wire logic [15:0] i_instr,
    input  wire logic        o_instr_ready,
    input  wire logic        o_busy,
    input  wire logic        o_skip,
    input  wire logic        o_done,
    input  wire logic  [1:0] o_cycles,
    input  wire logic  [1:0] o_phase,
    // Register port
    input  wire logic        i_reg_read,
    input  wire logic [31:0] o_reg_rdata
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    ////////////////////////////////////////////////////////////////////////////
    // Issue handshake and compare opcode decode
    wire       take   = i_instr_valid && o_instr_ready;
    wire [6:0] opc    = i_instr[15:9];
    wire       is_cmp = (opc == csda_pkg::CSDA_OP_SKIP_EQUAL) ||
                        (opc == csda_pkg::CSDA_OP_SKIP_GREATER) ||
                        (opc == csda_pkg::CSDA_OP_SKIP_LESS);
    ////////////////////////////////////////////////////////////////////////////
    // Steps of one instruction cycle and of the two skip lengths
    sequence s_quad;
        o_busy && o_phase == 2'h0 ##1 o_phase == 2'h1 ##1 o_phase == 2'h2 ##1 o_phase == 2'h3;
    endsequence
    sequence s_skip_one;
        o_skip [*4] ##1 (!o_skip && o_done && o_cycles == 2'h2);
    endsequence
    sequence s_skip_two;
        o_skip [*8] ##1 (!o_skip && o_done && o_cycles == 2'h3);
    endsequence
    property p_phase_walk; take |=> s_quad; endproperty
    property p_exec_end; take |-> ##5 (o_done ^ o_skip); endproperty
    property p_skip_len; $rose(o_skip) |-> s_skip_one or s_skip_two; endproperty
    property p_one_cycle; take && !is_cmp |-> ##5 (o_done && o_cycles == 2'h1); endproperty
    property p_noskip; o_done && o_cycles == 2'h1 |-> !$past(o_skip) && $past(o_phase) == 2'h3;
    endproperty
    property p_refuse; o_busy |-> !o_instr_ready; endproperty
    property p_idle; !o_busy |-> o_phase == 2'h0 && !o_skip; endproperty
    property p_done_pulse; o_done |=> !o_done; endproperty
    property p_rdata_zero; !$past(i_reg_read) |-> o_reg_rdata == 32'h0; endproperty
    a_phase_walk: assert property (p_phase_walk)
        else $error("phase walk after issue is wrong");
    a_exec_end: assert property (p_exec_end)
        else $error("first cycle neither finished nor skipped");
    a_skip_len: assert property (p_skip_len)
        else $error("skip length or cycle count wrong");
    a_one_cycle: assert property (p_one_cycle)
        else $error("non-compare word not done in one cycle");
    a_noskip: assert property (p_noskip)
        else $error("one-cycle count after a skip");
    a_refuse: assert property (p_refuse)
        else $error("ready while busy");
    a_idle: assert property (p_idle)
        else $error("phase or skip active while idle");
    a_done_pulse: assert property (p_done_pulse)
        else $error("done longer than one clock");
    a_rdata_zero: assert property (p_rdata_zero)
        else $error("read data outside the read answer cycle");
endmodule
bind csda_core csda_core_asserts u_csda_core_asserts (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .o_instr_ready(o_instr_ready), .o_busy(o_busy), .o_skip(o_skip),
    .o_done(o_done), .o_cycles(o_cycles), .o_phase(o_phase), .i_reg_read(i_reg_read),
    .o_reg_rdata(o_reg_rdata));

//--- testbench/csda_core_tb.sv
// Self-checking bench for the compare-skip and decimal-adjust sequencer
`timescale 1ns/1ps
module csda_core_tb;
    // Design stimulus and observation
    logic        i_core_clk, i_reset_n, i_instr_valid, i_next_two_word;
    logic [15:0] i_instr;
    logic  [7:0] i_reg_addr;
    logic [31:0] i_reg_wdata, o_reg_rdata, rv;
    logic        i_reg_write, i_reg_read, o_instr_ready, o_busy, o_skip, o_done;
    logic  [1:0] o_cycles, o_phase;
    int          error_cnt, n_tests, i;
    localparam logic [6:0] GT = csda_pkg::CSDA_OP_SKIP_GREATER;
    localparam logic [6:0] LT = csda_pkg::CSDA_OP_SKIP_LESS;
    localparam logic [6:0] EQ = csda_pkg::CSDA_OP_SKIP_EQUAL;

    csda_core u_csda_core (
        .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .i_next_two_word(i_next_two_word), .o_instr_ready(o_instr_ready),
        .o_busy(o_busy), .o_skip(o_skip), .o_done(o_done), .o_cycles(o_cycles),
        .o_phase(o_phase), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata));

    // 200 MHz clock
    always #2.5 i_core_clk = ~i_core_clk;

    ////////////////////////////////////////////////////////////////////////////
    // Verdict, comparison and register port tasks
    task automatic give_verdict();
        if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_reg_write <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_core_clk);
        i_reg_write <= 1'b0;
    endtask
    // Data is taken one edge after the strobe, once that edge has settled
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        i_reg_read <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_core_clk);
        i_reg_read <= 1'b0;
        #1;
        d = o_reg_rdata;
    endtask
    // Offer one word, then wait a bounded time for the done pulse
    task automatic issue(input logic [15:0] word, input logic two);
        int k;
        @(posedge i_core_clk);
        i_instr_valid   <= 1'b1;
        i_instr         <= word;
        i_next_two_word <= two;
        @(posedge i_core_clk);
        i_instr_valid <= 1'b0;
        #1;
        for (k = 0; k < 20 && o_done !== 1'b1; k++) begin
            @(posedge i_core_clk);
            #1;
        end
        if (o_done !== 1'b1) begin
            error_cnt++;
            give_verdict();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // One compare: operand placed at the expected address, outcome from the rules
    task automatic cmp(input logic [6:0] op, input logic acc, input logic [7:0] f,
                       input logic [11:0] ad, input logic [7:0] fv, input logic [7:0] wv,
                       input logic two);
        logic       sk;
        logic [1:0] cy;
        sk = (op == GT) ? (fv > wv) : (op == LT) ? (fv < wv) : (fv == wv);
        cy = sk ? (two ? 2'h3 : 2'h2) : 2'h1;
        wr(csda_pkg::CSDA_OFS_MEM_ADDR, {20'h0, ad});
        wr(csda_pkg::CSDA_OFS_MEM_DATA, {24'h0, fv});
        wr(csda_pkg::CSDA_OFS_WORK, {24'h0, wv});
        wr(csda_pkg::CSDA_OFS_STATUS, 32'h3);
        issue({op, acc, f}, two);
        chk({30'h0, o_cycles}, {30'h0, cy});
        rd(csda_pkg::CSDA_OFS_RESULT, rv);
        chk(rv & 32'h7, {29'h0, sk, cy});
        chk(rv & 32'h0FFF0000, {4'h0, ad, 16'h0});
        rd(csda_pkg::CSDA_OFS_WORK, rv);
        chk(rv & 32'hFF, {24'h0, wv});
        rd(csda_pkg::CSDA_OFS_STATUS, rv);
        chk(rv & 32'h3, 32'h3);
        rd(csda_pkg::CSDA_OFS_MEM_DATA, rv);
        chk(rv & 32'hFF, {24'h0, fv});
    endtask
    // Decimal adjust with the corrected value and carry worked out by hand
    task automatic decimal_adjust_working(input logic [7:0] wv, input logic dc, input logic c,
                       input logic [7:0] ew, input logic ec);
        wr(csda_pkg::CSDA_OFS_WORK, {24'h0, wv});
        wr(csda_pkg::CSDA_OFS_STATUS, {30'h0, dc, c});
        issue(csda_pkg::CSDA_OP_DECIMAL_ADJ, 1'b0);
        chk({30'h0, o_cycles}, 32'h1);
        rd(csda_pkg::CSDA_OFS_WORK, rv);
        chk(rv & 32'hFF, {24'h0, ew});
        rd(csda_pkg::CSDA_OFS_STATUS, rv);
        chk(rv & 32'h3, {30'h0, dc, ec});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {i_core_clk, i_reset_n, i_instr_valid, i_next_two_word} = 4'h0;
        {i_reg_write, i_reg_read, i_reg_addr, i_instr, i_reg_wdata} = '0;
        error_cnt = 0;
        n_tests   = 0;
        repeat (5) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        // Reset values, and an unmapped place that ignores writes
        wr(8'h20, 32'hFFFFFFFF);
        for (i = 0; i < 9; i++) begin
            rd((i == 8) ? 8'h20 : 8'(i * 4), rv);
            // Memory data has no reset value, so only that offset goes unchecked
            if (i != 6) chk(rv, 32'h0);
        end
        wr(csda_pkg::CSDA_OFS_BANK, 32'h5);
        wr(csda_pkg::CSDA_OFS_INDEX, 32'h200);
        cmp(GT, 1'b0, 8'h20, 12'h020, 8'hFF, 8'h00, 1'b0);
        cmp(GT, 1'b1, 8'h33, 12'h533, 8'h40, 8'h40, 1'b0);
        cmp(GT, 1'b0, 8'h90, 12'hF90, 8'h41, 8'h40, 1'b1);
        cmp(LT, 1'b0, 8'h7F, 12'h07F, 8'h00, 8'hFF, 1'b1);
        cmp(LT, 1'b1, 8'h80, 12'h580, 8'h80, 8'h7F, 1'b0);
        cmp(EQ, 1'b1, 8'hFF, 12'h5FF, 8'h5A, 8'h5A, 1'b0);
        cmp(EQ, 1'b0, 8'h00, 12'h000, 8'h5A, 8'h5B, 1'b0);
        wr(csda_pkg::CSDA_OFS_CTRL, 32'h1);
        cmp(GT, 1'b0, 8'h5F, 12'h25F, 8'h10, 8'h0F, 1'b0);
        cmp(LT, 1'b0, 8'h60, 12'h060, 8'h10, 8'h10, 1'b0);
        cmp(LT, 1'b1, 8'h10, 12'h510, 8'h0F, 8'h10, 1'b1);
        decimal_adjust_working(8'h41, 1'b1, 1'b0, 8'h47, 1'b0);
        decimal_adjust_working(8'h0A, 1'b0, 1'b0, 8'h10, 1'b0);
        decimal_adjust_working(8'h49, 1'b0, 1'b0, 8'h49, 1'b0);
        decimal_adjust_working(8'h32, 1'b1, 1'b1, 8'h98, 1'b1);
        decimal_adjust_working(8'h9A, 1'b0, 1'b0, 8'h00, 1'b1);
        decimal_adjust_working(8'hA0, 1'b0, 1'b0, 8'h00, 1'b1);
        // A word that is no instruction runs one idle cycle
        issue(16'hFFFF, 1'b1);
        chk({30'h0, o_cycles}, 32'h1);
        give_verdict();
    end
endmodule
